/* File: logic/ebi_core.v */
// Purpose: external memory bus interface between the CPU data port and pins
// Assumes: CPU pulses acc_req for one cycle and holds addr/wdata stable until acc_done
// Notes:   Functional notes
`timescale 1ns/10ps
`include "ebi_regs.vh"
module ebi_core (
   clk,                 // System clock
   rst_n,               // Async reset, active low
   ext_bus_enable,      // Interface enable
   sector_limit_sel,    // Sector boundary code
   wait_upper_sel,      // Upper sector wait code
   wait_lower_sel,      // Lower sector wait code
   high_addr_mask,      // High address pin release code
   bus_keeper_en,       // Keeper enable
   acc_req,             // CPU data access request, one cycle pulse
   acc_write,           // Access is a store
   acc_addr,            // Access address
   acc_wdata,           // Store data
   acc_done,            // Access complete pulse
   acc_rdata,           // Load data from external bus
   acc_ext,             // Completed access was external
   ad_in,               // Muxed bus pin input
   addr_data_low_bus,   // Muxed bus pin output
   ad_oe,               // Muxed bus drive enable
   ad_keep,             // Keeper active
   addr_high_bus,       // High address output
   ah_oe,               // Per-pin high address enable
   address_latch_strobe, // Latch gate
   read_strobe_n,       // Read strobe, active low
   store_strobe_n,      // Write strobe, active low
   ctl_oe               // Strobe pin enable
);
   input  wire        clk;                  // System clock
   input  wire        rst_n;                // Async reset
   input  wire        ext_bus_enable;       // Interface enable
   input  wire [2:0]  sector_limit_sel;     // Sector code
   input  wire [1:0]  wait_upper_sel;       // Upper wait
   input  wire [1:0]  wait_lower_sel;       // Lower wait
   input  wire [2:0]  high_addr_mask;       // High mask
   input  wire        bus_keeper_en;        // Keeper enable
   input  wire        acc_req;              // Request
   input  wire        acc_write;            // Store
   input  wire [15:0] acc_addr;             // Address
   input  wire [7:0]  acc_wdata;            // Store data
   output reg         acc_done;             // Done pulse
   output reg  [7:0]  acc_rdata;            // Load data
   output reg         acc_ext;              // External flag
   input  wire [7:0]  ad_in;                // Bus input
   output reg  [7:0]  addr_data_low_bus;    // Bus output
   output reg         ad_oe;                // Bus enable
   output reg         ad_keep;              // Keeper
   output reg  [7:0]  addr_high_bus;        // High address
   output reg  [7:0]  ah_oe;                // High enables
   output reg         address_latch_strobe; // Latch gate
   output reg         read_strobe_n;        // Read strobe
   output reg         store_strobe_n;       // Write strobe
   output reg         ctl_oe;               // Strobe enables

   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_DATA = 3'h2;
   localparam ST_WAIT = 3'h3;
   localparam ST_END  = 3'h4;
   localparam ST_HOLD = 3'h5;
   localparam ST_CAPT = 3'h6;

   ////////////////////////////////////////////////////////////////
   // Input synchronisers for the bus pins
   // Pins are asynchronous to clk; only the second stage is read
   reg [7:0] ad_s1_reg;
   reg [7:0] ad_s2_reg;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ad_s1_reg <= 8'h00;
         ad_s2_reg <= 8'h00;
      end else begin
         ad_s1_reg <= ad_in;
         ad_s2_reg <= ad_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Decode
   function is_external;
      input [15:0] a;
      begin
         is_external = (a > `EBI_INT_TOP);
      end
   endfunction

   function [7:0] high_enables;
      input [2:0] m;
      begin
         high_enables = 8'hff >> m;
         if (m == 3'h7) begin
            high_enables = 8'h00;
         end
      end
   endfunction

   function strobe_window;
      input [2:0] nxt;
      input [2:0] cur;
      begin
         strobe_window = (nxt == ST_DATA) || (nxt == ST_WAIT) ||
                         ((nxt == ST_END) && ((cur == ST_DATA) || (cur == ST_WAIT)));
      end
   endfunction

   function [1:0] wait_cycles;
      input [1:0] code;
      begin
         wait_cycles = (code == `EBI_WS_ONE) ? 2'h1 : 2'h2;
         if (code == `EBI_WS_NONE) begin
            wait_cycles = 2'h0;
         end
      end
   endfunction

   wire [1:0] sect_wait;
   ebi_sector u_sector (
      .addr             (acc_addr),
      .sector_limit_sel (sector_limit_sel),
      .wait_upper       (wait_upper_sel),
      .wait_lower       (wait_lower_sel),
      .wait_state_sel   (sect_wait)
   );

   ////////////////////////////////////////////////////////////////
   // Access sequencer
   reg [2:0]  state_reg;
   reg [2:0]  state_next;
   reg [1:0]  wcnt_reg;
   reg [1:0]  wcnt_next;
   reg [1:0]  ws_reg;
   reg [1:0]  ws_next;
   reg        ext_reg;
   reg        ext_next;
   reg        wr_reg;
   reg        wr_next;

   always @* begin
      state_next = state_reg;
      wcnt_next  = wcnt_reg;
      ws_next    = ws_reg;
      ext_next   = ext_reg;
      wr_next    = wr_reg;
      case (state_reg)
         ST_IDLE: begin
            if (acc_req) begin
               ext_next = is_external(acc_addr);
               wr_next  = acc_write;
               ws_next  = is_external(acc_addr) ? sect_wait : `EBI_WS_NONE;
               state_next = ST_ADDR;
            end
         end
         ST_ADDR: begin
            state_next = ST_DATA;
         end
         ST_DATA: begin
            wcnt_next = wait_cycles(ws_reg);
            state_next = (ws_reg == `EBI_WS_NONE) ? ST_END : ST_WAIT;
         end
         ST_WAIT: begin
            wcnt_next = wcnt_reg - 2'h1;
            if (wcnt_reg == 2'h1) begin
               state_next = ST_END;
            end
         end
         ST_END: begin
            // Extra cycle lets read data clear the synchroniser
            if (ext_reg && !wr_reg) begin
               state_next = ST_CAPT;
            end else if (ws_reg == `EBI_WS_TWO_HOLD) begin
               state_next = ST_HOLD;
            end else begin
               state_next = ST_IDLE;
            end
         end
         ST_CAPT: begin
            state_next = (ws_reg == `EBI_WS_TWO_HOLD) ? ST_HOLD : ST_IDLE;
         end
         ST_HOLD: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         wcnt_reg  <= 2'h0;
         ws_reg    <= 2'h0;
         ext_reg   <= 1'b0;
         wr_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         wcnt_reg  <= wcnt_next;
         ws_reg    <= ws_next;
         ext_reg   <= ext_next;
         wr_reg    <= wr_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read capture qualifiers, combinational
   wire ext_live   = ext_bus_enable && ext_reg;
   wire rd_end     = (state_reg == ST_CAPT) || ((state_reg == ST_END) && !ext_reg);
   wire rd_data_ok = ext_live && !wr_reg && (state_reg == ST_CAPT);

   ////////////////////////////////////////////////////////////////
   // Completion and read capture
   // Read data taken in the capture state, two stages after the pins
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_done  <= 1'b0;
         acc_rdata <= 8'h00;
         acc_ext   <= 1'b0;
      end else begin
         acc_done <= (state_next == ST_IDLE) && (state_reg != ST_IDLE);
         acc_ext  <= ext_reg;
         if (rd_data_ok) begin
            acc_rdata <= ad_s2_reg;
         end else if (rd_end) begin
            acc_rdata <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Pin outputs
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_data_low_bus    <= 8'h00;
         ad_oe                <= 1'b0;
         ad_keep              <= 1'b0;
         addr_high_bus        <= 8'h00;
         ah_oe                <= 8'h00;
         address_latch_strobe <= 1'b0;
         read_strobe_n        <= 1'b1;
         store_strobe_n       <= 1'b1;
         ctl_oe               <= 1'b0;
      end else begin
         ad_keep <= bus_keeper_en;
         ctl_oe  <= ext_bus_enable;
         ah_oe   <= ext_bus_enable ? high_enables(high_addr_mask) : 8'h00;
         if (!ext_bus_enable) begin
            ad_oe                <= 1'b0;
            address_latch_strobe <= 1'b0;
            read_strobe_n        <= 1'b1;
            store_strobe_n       <= 1'b1;
         end else begin
            // Address phase: latch open, low byte driven
            if (state_next == ST_ADDR) begin
               addr_data_low_bus    <= acc_addr[7:0];
               addr_high_bus        <= acc_addr[15:8];
               ad_oe                <= 1'b1;
               address_latch_strobe <= 1'b1;
            end else if (state_next == ST_DATA) begin
               address_latch_strobe <= 1'b0;
               if (wr_reg) begin
                  addr_data_low_bus <= acc_wdata;
                  ad_oe             <= 1'b1;
               end else begin
                  ad_oe <= 1'b0;
               end
            end else if (state_next == ST_IDLE) begin
               ad_oe                <= 1'b0;
               address_latch_strobe <= 1'b0;
            end else begin
               address_latch_strobe <= 1'b0;
            end
            read_strobe_n  <= ~(ext_reg && !wr_reg &&
                               strobe_window(state_next, state_reg));
            store_strobe_n <= ~(ext_reg && wr_reg &&
                               strobe_window(state_next, state_reg));
         end
      end
   end
endmodule

/* File: logic/ebi_regs.vh */
// Purpose: constants for the external bus interface
// Assumes: 16-bit data space, internal SRAM ends at 0x21ff
// Notes:   definitions only
`ifndef EBI_REGS_VH
`define EBI_REGS_VH
`define EBI_INT_TOP        16'h21ff
`define EBI_EXT_BASE       16'h2200
`define EBI_WS_NONE        2'h0
`define EBI_WS_ONE         2'h1
`define EBI_WS_TWO         2'h2
`define EBI_WS_TWO_HOLD    2'h3
`define EBI_SECT_STEP      16'h2000
`define EBI_HI_BITS        4'h8
`endif

/* File: logic/ebi_sector.v */
// Purpose: sector decode and wait-state selection for one external address
// Assumes: address already known to be external
// Notes:   combinational
`timescale 1ns/10ps
`include "ebi_regs.vh"
module ebi_sector (
   addr,          // Access address
   sector_limit_sel, // Sector boundary code
   wait_upper,    // Upper sector wait code
   wait_lower,    // Lower sector wait code
   wait_state_sel // Chosen wait code
);
   input  wire [15:0] addr;             // Access address
   input  wire [2:0]  sector_limit_sel; // Sector boundary code
   input  wire [1:0]  wait_upper;       // Upper sector wait code
   input  wire [1:0]  wait_lower;       // Lower sector wait code
   output reg  [1:0]  wait_state_sel;   // Chosen wait code

   reg [15:0] limit;
   always @* begin
      limit = {sector_limit_sel, 13'h0}; // 0x4000..0xe000 by 0x2000
      if (sector_limit_sel[2:1] == 2'h0) begin
         wait_state_sel = wait_upper;
      end else if (addr >= limit) begin
         wait_state_sel = wait_upper;
      end else begin
         wait_state_sel = wait_lower;
      end
   end
endmodule

/* File: test/ebi_core_props.sv */
// Purpose: pin timing checks for ebi_core
// Assumes: configuration held steady during an access
// Notes:   bound into ebi_core
`timescale 1ns/10ps
module ebi_core_props (
   input wire        clk, rst_n, ext_bus_enable, bus_keeper_en, acc_req, acc_write,
   input wire [2:0]  sector_limit_sel, high_addr_mask,
   input wire [1:0]  wait_upper_sel, wait_lower_sel,
   input wire [15:0] acc_addr,
   input wire [7:0]  acc_wdata, addr_data_low_bus, addr_high_bus, ah_oe,
   input wire        acc_done, ad_oe, ad_keep, address_latch_strobe,
   input wire        read_strobe_n, store_strobe_n, ctl_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [3:0] cnt_reg;
   logic [3:0] lat_reg;
   wire ext = acc_addr > 16'h21ff;
   wire up = sector_limit_sel < 3'h2 || acc_addr >= {sector_limit_sel, 13'h0};
   wire [1:0] ws = !ext ? 2'h0 : up ? wait_upper_sel : wait_lower_sel;
   wire ena = acc_req && ext_bus_enable;
   ////////////////////////////////////////////////////////////////
   // Cycles since the request
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 4'h0;
         lat_reg <= 4'h0;
      end else if (acc_req) begin
         cnt_reg <= 4'h1;
         lat_reg <= 4'h4 + {2'h0, ws} + {3'h0, ext && !acc_write};
      end else if (cnt_reg != 4'hf) begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////////
   AST_LATENCY: assert property (acc_done |-> cnt_reg == lat_reg)
      else $error("done at wrong cycle");
   AST_ALE_LOW: assert property (ena |-> ##1 address_latch_strobe ##1
      !address_latch_strobe [*3]) else $error("latch strobe shape");
   AST_ADDR_LOW: assert property (ena |-> ##1 ad_oe &&
      addr_data_low_bus == acc_addr[7:0]) else $error("low address missing");
   AST_ADDR_HIGH: assert property (ena |-> ##1
      (addr_high_bus & ah_oe) == (acc_addr[15:8] & ah_oe)) else $error("high address");
   AST_MASK: assert property (address_latch_strobe && ctl_oe |-> ah_oe ==
      (&high_addr_mask ? 8'h00 : 8'hff >> high_addr_mask)) else $error("high pin enables");
   AST_WRITE: assert property (ena && acc_write && ext |-> ##2 !store_strobe_n &&
      ad_oe && addr_data_low_bus == acc_wdata) else $error("write phase");
   AST_READ: assert property (ena && !acc_write && ext |-> ##2
      !read_strobe_n && !ad_oe) else $error("read phase");
   AST_INTERNAL: assert property (acc_req && !ext |-> ##1
      (read_strobe_n && store_strobe_n) [*4]) else $error("strobe on internal");
   AST_RELEASE: assert property (!ext_bus_enable && !$past(ext_bus_enable) |->
      !ad_oe && !ctl_oe && ah_oe == 8'h00) else $error("pins not released");
   AST_OWN: assert property (ext_bus_enable && $past(ext_bus_enable) |-> ctl_oe)
      else $error("pins not owned");
   AST_KEEP: assert property ($rose(bus_keeper_en) |=> ad_keep)
      else $error("keeper not on");
   cover property (ena && acc_write && ext);
   cover property (acc_done && lat_reg == 4'h7);
   cover property (acc_req && !ext);
endmodule
bind ebi_core ebi_core_props i_props (.*);

/* File: test/ebi_mem_model.sv */
// Purpose: address latch plus byte memory on the far side
// Assumes: latch transparent while its gate is high
// Notes:   released bus shows inverse of last level, or the last level itself when ad_keep is high
`timescale 1ns/10ps
module ebi_mem_model (
   input  wire       clk, ad_oe, ad_keep, address_latch_strobe,
   input  wire       read_strobe_n, store_strobe_n, ctl_oe,
   input  wire [7:0] addr_data_low_bus, addr_high_bus,
   output logic [7:0] ad_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] lo_reg;
   logic [7:0] last_reg = 8'h00;
   // Gate is high a whole cycle; the edge that ends it still sees the address
   always @(posedge clk) if (address_latch_strobe) lo_reg <= ad_in;
   always_comb begin
      if (ad_oe)
         ad_in = addr_data_low_bus;
      else if (ctl_oe && !read_strobe_n)
         ad_in = mem[{addr_high_bus, lo_reg}];
      else
         ad_in = ad_keep ? last_reg : ~last_reg;
   end
   always @(posedge clk) begin
      last_reg <= ad_in;
      if (ctl_oe && !store_strobe_n && ad_oe)
         mem[{addr_high_bus, lo_reg}] <= ad_in;
   end
endmodule

/* File: test/test_ebi_core.sv */
// Purpose: self-checking bench for ebi_core
// Assumes: one access at a time, inputs driven on falling edges
// Notes:   memory model answers reads
`timescale 1ns/10ps
module test_ebi_core;
   logic clk, rst_n, ext_bus_enable, bus_keeper_en, acc_req, acc_write;
   logic [2:0] sector_limit_sel, high_addr_mask;
   logic [1:0] wait_upper_sel, wait_lower_sel;
   logic [15:0] acc_addr;
   logic [7:0] acc_wdata, acc_rdata, ad_in, addr_data_low_bus, addr_high_bus, ah_oe, ah_cap;
   logic acc_done, acc_ext, ad_oe, ad_keep, address_latch_strobe;
   logic read_strobe_n, store_strobe_n, ctl_oe;
   int fails, cmp_count, lat, strb, drv;
   ebi_core i_dut (.*);
   ebi_mem_model i_mem (.*);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      {acc_req, acc_write, acc_addr, acc_wdata} = {1'b1, wr, a, d};
      @(negedge clk);
      acc_req = 1'b0;
      {lat, strb, drv, ah_cap} = {32'd1, 32'd0, 32'd0, 8'h5a};
      while (acc_done !== 1'b1 && lat < 20) begin
         if (read_strobe_n === 1'b0 || store_strobe_n === 1'b0)
            strb++;
         if (ad_oe !== 1'b0)
            drv++;
         if (address_latch_strobe === 1'b1)
            ah_cap = ah_oe;
         @(negedge clk);
         lat++;
      end
      if (lat >= 20) begin
         fails++;
         complete_run();
      end
   endtask
   task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic [3:0] n);
      access(1'b1, a, d);
      check(16'(lat), {12'h0, n}, "write latency");
      access(1'b0, a, 8'h00);
      check(16'(lat), {12'h0, n} + 16'h0001, "read latency");
      check({7'h0, acc_ext, acc_rdata}, {8'h01, d}, "read data");
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {rst_n, ext_bus_enable, bus_keeper_en, acc_req, acc_write} = 5'h00;
      {sector_limit_sel, high_addr_mask, wait_upper_sel, wait_lower_sel} = 10'h000;
      {acc_addr, acc_wdata, fails, cmp_count} = {24'h000000, 32'd0, 32'd0};
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      ext_bus_enable = 1'b1;
      for (int w = 0; w < 4; w++) begin
         wait_upper_sel = w[1:0];
         xfer(16'h8000 + 16'(w), 8'h5a ^ 8'(w), 4'(4 + w));
      end
      $display("wait state test done");
      {sector_limit_sel, wait_lower_sel, wait_upper_sel} = {3'h4, 2'h2, 2'h0};
      xfer(16'h7fff, 8'hc3, 4'h6);
      xfer(16'h8000, 8'h3c, 4'h4);
      xfer(16'h2200, 8'h81, 4'h6);
      sector_limit_sel = 3'h1;
      xfer(16'h2200, 8'h18, 4'h4);
      $display("sector test done");
      access(1'b1, 16'h21ff, 8'hee);
      check(16'(strb), 16'h0000, "internal strobes");
      check({15'h0, acc_ext}, 16'h0000, "internal flag");
      check(16'(drv > 0), 16'h0001, "internal bus activity");
      $display("internal test done");
      for (int m = 0; m < 8; m++) begin
         high_addr_mask = m[2:0];
         access(1'b0, 16'h9000, 8'h00);
         check({8'h0, ah_cap}, {8'h0, m == 7 ? 8'h00 : 8'hff >> m}, "high pins");
      end
      $display("mask test done");
      {high_addr_mask, ext_bus_enable, bus_keeper_en} = {3'h0, 1'b0, 1'b1};
      access(1'b1, 16'h9000, 8'h77);
      check(16'(drv), 16'h0000, "disabled bus drive");
      check({6'h0, ctl_oe, ad_keep, ah_oe}, 16'h0100, "disabled pins");
      check({15'h0, acc_ext}, 16'h0001, "disabled external flag");
      access(1'b0, 16'h9000, 8'h00);
      check({7'h0, acc_ext, acc_rdata}, 16'h0100, "disabled read");
      check(16'(lat), 16'h0005, "disabled read latency");
      $display("disable test done");
      complete_run();
   end
endmodule
